/* File: design/edge_latch_regs.vh */
`ifndef EDGE_LATCH_REGS_VH
`define EDGE_LATCH_REGS_VH

// Register offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_FLAGS 8'h08
`define OFS_LATCH_Q 8'h0c

// Control register fields
`define CTRL_DETECT_EN_BIT 0
`define CTRL_RESET 32'h0000_0001

// Status register fields
`define STATUS_DFF_Q_BIT 0
`define STATUS_JK_Q_BIT 1
`define STATUS_UNSTABLE_LSB 4

// Sticky flag fields: dff, jk, sr latch, data latch
`define FLAG_DFF_BIT 0
`define FLAG_JK_BIT 1
`define FLAG_SRL_BIT 2
`define FLAG_DL_BIT 3
`define FLAGS_RESET 4'h0

// Latch readback fields
`define LATCH_Q_SRL_LSB 0
`define LATCH_Q_DL_LSB 8

// Array widths of the instances in the top level
`define SRL_WIDTH 4
`define DL_WIDTH 8

// Storage reset value of every element: true 0, complement 1
`define Q_RESET 1'b0
`define QN_RESET 1'b1

// Synchroniser reset holds idle pins: presets and clears high, the rest low
`define PINS_RESET 35'h0_c330_0600

`endif

/* File: design/gated_latch_array.v */
`timescale 1ns/1ps
`include "edge_latch_regs.vh"

module gated_latch_array #(
    parameter WIDTH = 4,
    parameter IS_SR = 1
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Shared controls, already in the ref_clk domain
    input wire preset_n,
    input wire async_reset_n,
    input wire gate,
    // Per-bit inputs: set or data, and reset (set-reset variant only)
    input wire [WIDTH-1:0] set_or_data,
    input wire [WIDTH-1:0] reset_in,
    // Per-bit outputs and one unstable flag shared by all bits
    output reg [WIDTH-1:0] q_r,
    output reg [WIDTH-1:0] q_n_r,
    output wire unstable
);

    reg [WIDTH-1:0] q_nxt;
    reg [WIDTH-1:0] q_n_nxt;
    reg [WIDTH-1:0] both_set;
    integer i;

    // Preset and clear are shared by all bits and override gate and data
    always @* begin
        q_nxt = q_r;
        q_n_nxt = q_n_r;
        both_set = {WIDTH{1'b0}};
        for (i = 0; i < WIDTH; i = i + 1) begin
            if (!preset_n && !async_reset_n) begin // (R7)
                q_nxt[i] = 1'b1;
                q_n_nxt[i] = 1'b1;
            end else if (!async_reset_n) begin // (R7)
                q_nxt[i] = 1'b0;
                q_n_nxt[i] = 1'b1;
            end else if (!preset_n) begin // (R7)
                q_nxt[i] = 1'b1;
                q_n_nxt[i] = 1'b0;
            end else if (gate) begin // (R9)
                if (IS_SR != 0) begin
                    both_set[i] = set_or_data[i] & reset_in[i];
                    if (set_or_data[i] && reset_in[i]) begin // (R5)
                        q_nxt[i] = 1'b1;
                        q_n_nxt[i] = 1'b1;
                    end else if (set_or_data[i]) begin // (R5)
                        q_nxt[i] = 1'b1;
                        q_n_nxt[i] = 1'b0;
                    end else if (reset_in[i]) begin // (R5)
                        q_nxt[i] = 1'b0;
                        q_n_nxt[i] = 1'b1;
                    end
                end else begin
                    q_nxt[i] = set_or_data[i]; // (R6)
                    q_n_nxt[i] = ~set_or_data[i]; // (R8)
                end
            end
        end
    end

    // Level sensing is sampled on ref_clk, so a gate pulse shorter than a period can be missed
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= {WIDTH{`Q_RESET}};
            q_n_r <= {WIDTH{`QN_RESET}};
        end else begin
            q_r <= q_nxt;
            q_n_r <= q_n_nxt;
        end
    end

    assign unstable = (~preset_n & ~async_reset_n) | (preset_n & async_reset_n & gate & (|both_set)); // (R12)

endmodule // gated_latch_array

/* File: design/dual_edge_flops_gated_latches.v */
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "edge_latch_regs.vh"

// Behaviour
// (R1) D flop: preset/clear low force outputs, both low make both high.
// (R2) D flop captures data on enabled rising or falling edge, else holds.
// (R3) JK flop: same overrides; enabled edge holds, clears or sets per J,K.
// (R4) JK flop with J and K both high toggles on an enabled edge.
// (R5) SR latch with gate high sets, clears, holds; S and R high unstable.
// (R6) D latch with gate high follows data, with gate low holds.
// (R7) Latch preset and clear override gate and data, both low unstable.
// (R8) Latch outputs are complementary except in unstable conditions.
// (R9) One preset, clear and gate act together on every latch bit.
// (R10) Latch array width is a parameter chosen at instantiation.
// (R11) Both set-reset and D latch arrays are provided.
// (R12) Unstable input combinations are flagged, not relied upon.
module dual_edge_flops_gated_latches (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Dual-edge D flop
    input wire dff_clk,
    input wire dff_rising_edge_enable,
    input wire dff_falling_edge_enable,
    input wire dff_preset_n,
    input wire dff_async_reset_n,
    input wire dff_d,
    output reg dff_q,
    output reg dff_q_n,
    // Dual-edge J-K flop
    input wire jk_clk,
    input wire jk_rising_edge_enable,
    input wire jk_falling_edge_enable,
    input wire jk_preset_n,
    input wire jk_async_reset_n,
    input wire jk_j,
    input wire jk_k,
    output reg jk_q,
    output reg jk_q_n,
    // Set-reset latch array
    input wire srl_preset_n,
    input wire srl_async_reset_n,
    input wire srl_gate,
    input wire [`SRL_WIDTH-1:0] srl_set,
    input wire [`SRL_WIDTH-1:0] srl_reset,
    output wire [`SRL_WIDTH-1:0] srl_q,
    output wire [`SRL_WIDTH-1:0] srl_q_n,
    // Data latch array
    input wire dl_preset_n,
    input wire dl_async_reset_n,
    input wire dl_gate,
    input wire [`DL_WIDTH-1:0] dl_data,
    output wire [`DL_WIDTH-1:0] dl_q,
    output wire [`DL_WIDTH-1:0] dl_q_n,
    // Unstable condition seen since last clear
    output wire unstable_seen
);

    localparam IN_W = 13 + 6 + 2 * `SRL_WIDTH + `DL_WIDTH;

    // All pin inputs share one synchroniser so data and clocks keep their alignment
    wire [IN_W-1:0] pins_raw;
    reg [IN_W-1:0] pins_meta_r;
    reg [IN_W-1:0] pins_sync_r;

    wire s_dff_clk;
    wire s_dff_re;
    wire s_dff_fe;
    wire s_dff_pre_n;
    wire s_dff_clr_n;
    wire s_dff_d;
    wire s_jk_clk;
    wire s_jk_re;
    wire s_jk_fe;
    wire s_jk_pre_n;
    wire s_jk_clr_n;
    wire s_jk_j;
    wire s_jk_k;
    wire s_srl_pre_n;
    wire s_srl_clr_n;
    wire s_srl_gate;
    wire [`SRL_WIDTH-1:0] s_srl_set;
    wire [`SRL_WIDTH-1:0] s_srl_reset;
    wire s_dl_pre_n;
    wire s_dl_clr_n;
    wire s_dl_gate;
    wire [`DL_WIDTH-1:0] s_dl_data;

    assign pins_raw = {dff_clk, dff_rising_edge_enable, dff_falling_edge_enable, dff_preset_n,
                       dff_async_reset_n, dff_d,
                       jk_clk, jk_rising_edge_enable, jk_falling_edge_enable, jk_preset_n,
                       jk_async_reset_n, jk_j, jk_k,
                       srl_preset_n, srl_async_reset_n, srl_gate, srl_set, srl_reset,
                       dl_preset_n, dl_async_reset_n, dl_gate, dl_data};

    assign {s_dff_clk, s_dff_re, s_dff_fe, s_dff_pre_n, s_dff_clr_n, s_dff_d,
            s_jk_clk, s_jk_re, s_jk_fe, s_jk_pre_n, s_jk_clr_n, s_jk_j, s_jk_k,
            s_srl_pre_n, s_srl_clr_n, s_srl_gate, s_srl_set, s_srl_reset,
            s_dl_pre_n, s_dl_clr_n, s_dl_gate, s_dl_data} = pins_sync_r;

    // Clearing to all zeros would read as preset and clear both low and fake an unstable state
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_meta_r <= `PINS_RESET;
            pins_sync_r <= `PINS_RESET;
        end else begin
            pins_meta_r <= pins_raw;
            pins_sync_r <= pins_meta_r;
        end
    end

    // Previous primitive clock levels for edge detection
    reg dff_clk_prev_r;
    reg jk_clk_prev_r;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dff_clk_prev_r <= 1'b0;
            jk_clk_prev_r <= 1'b0;
        end else begin
            dff_clk_prev_r <= s_dff_clk;
            jk_clk_prev_r <= s_jk_clk;
        end
    end

    wire dff_take;
    wire jk_take;

    // A steady clock or both enables low gives no take, so the flop holds
    assign dff_take = (s_dff_clk & ~dff_clk_prev_r & s_dff_re) | (~s_dff_clk & dff_clk_prev_r & s_dff_fe); // (R2)
    assign jk_take = (s_jk_clk & ~jk_clk_prev_r & s_jk_re) | (~s_jk_clk & jk_clk_prev_r & s_jk_fe); // (R3)

    // Next {q, q_n} of a dual-edge flop; preset and clear win over the edge
    function [1:0] flop_next;
        input pre_n;
        input clr_n;
        input take;
        input cap;
        input [1:0] held;
        begin
            if (!pre_n && !clr_n) begin
                flop_next = 2'b11;
            end else if (!clr_n) begin
                flop_next = 2'b01;
            end else if (!pre_n) begin
                flop_next = 2'b10;
            end else if (take) begin
                flop_next = {cap, ~cap};
            end else begin
                flop_next = held;
            end
        end
    endfunction

    // Value a J-K flop takes on an enabled edge
    function jk_eval;
        input j;
        input k;
        input q_old;
        begin
            case ({j, k})
                2'b00: begin
                    jk_eval = q_old;
                end
                2'b01: begin
                    jk_eval = 1'b0;
                end
                2'b10: begin
                    jk_eval = 1'b1;
                end
                default: begin
                    jk_eval = ~q_old;
                end
            endcase
        end
    endfunction

    wire [1:0] dff_nxt;
    wire [1:0] jk_nxt;

    assign dff_nxt = flop_next(s_dff_pre_n, s_dff_clr_n, dff_take, s_dff_d, {dff_q, dff_q_n}); // (R1)
    assign jk_nxt = flop_next(s_jk_pre_n, s_jk_clr_n, jk_take, jk_eval(s_jk_j, s_jk_k, jk_q), {jk_q, jk_q_n}); // (R4)

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dff_q <= `Q_RESET;
            dff_q_n <= `QN_RESET;
            jk_q <= `Q_RESET;
            jk_q_n <= `QN_RESET;
        end else begin
            dff_q <= dff_nxt[1]; // (R2)
            dff_q_n <= dff_nxt[0];
            jk_q <= jk_nxt[1]; // (R3)
            jk_q_n <= jk_nxt[0];
        end
    end

    // The two latch variants, width set per instance
    wire srl_unstable;
    wire dl_unstable;

    gated_latch_array #(
        .WIDTH(`SRL_WIDTH),
        .IS_SR(1)
    ) u_srl (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .preset_n(s_srl_pre_n),
        .async_reset_n(s_srl_clr_n),
        .gate(s_srl_gate),
        .set_or_data(s_srl_set),
        .reset_in(s_srl_reset),
        .q_r(srl_q),
        .q_n_r(srl_q_n),
        .unstable(srl_unstable)
    ); // (R11)

    gated_latch_array #(
        .WIDTH(`DL_WIDTH),
        .IS_SR(0)
    ) u_dl (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .preset_n(s_dl_pre_n),
        .async_reset_n(s_dl_clr_n),
        .gate(s_dl_gate),
        .set_or_data(s_dl_data),
        .reset_in({`DL_WIDTH{1'b0}}),
        .q_r(dl_q),
        .q_n_r(dl_q_n),
        .unstable(dl_unstable)
    ); // (R10)

    // Live unstable conditions, one bit per element
    wire [3:0] unstable_now;

    assign unstable_now[`FLAG_DFF_BIT] = ~s_dff_pre_n & ~s_dff_clr_n; // (R12)
    assign unstable_now[`FLAG_JK_BIT] = ~s_jk_pre_n & ~s_jk_clr_n; // (R12)
    assign unstable_now[`FLAG_SRL_BIT] = srl_unstable;
    assign unstable_now[`FLAG_DL_BIT] = dl_unstable;

    // Control and sticky flags
    reg [31:0] ctrl_r;
    reg [3:0] flags_r;
    reg [3:0] flags_nxt;
    wire wr_ctrl;
    wire wr_flags;
    wire detect_en;

    assign wr_ctrl = reg_wr && (reg_addr == `OFS_CTRL);
    assign wr_flags = reg_wr && (reg_addr == `OFS_FLAGS);
    assign detect_en = ctrl_r[`CTRL_DETECT_EN_BIT];

    // Write one to clear; a condition present in the clearing cycle still sets the flag
    always @* begin
        flags_nxt = flags_r;
        if (wr_flags) begin
            flags_nxt = flags_nxt & ~reg_wdata[3:0];
        end
        if (detect_en) begin
            flags_nxt = flags_nxt | unstable_now; // (R12)
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `CTRL_RESET;
            flags_r <= `FLAGS_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= {31'h0000_0000, reg_wdata[`CTRL_DETECT_EN_BIT]};
            end
            flags_r <= flags_nxt;
        end
    end

    assign unstable_seen = |flags_r;

    // Read data stand only in the cycle after the strobe, zero otherwise
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        case (reg_addr)
            `OFS_CTRL: begin
                rd_mux = ctrl_r;
            end
            `OFS_STATUS: begin
                rd_mux[`STATUS_DFF_Q_BIT] = dff_q;
                rd_mux[`STATUS_JK_Q_BIT] = jk_q;
                rd_mux[`STATUS_UNSTABLE_LSB +: 4] = unstable_now;
            end
            `OFS_FLAGS: begin
                rd_mux[3:0] = flags_r;
            end
            `OFS_LATCH_Q: begin
                rd_mux[`LATCH_Q_SRL_LSB +: `SRL_WIDTH] = srl_q;
                rd_mux[`LATCH_Q_DL_LSB +: `DL_WIDTH] = dl_q;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule // dual_edge_flops_gated_latches

/* File: tb/edge_latch_monitor.sv */
`timescale 1ns/1ps
`include "edge_latch_regs.vh"
module edge_latch_monitor (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Dual-edge D flop
    input wire dff_clk,
    input wire dff_rising_edge_enable,
    input wire dff_falling_edge_enable,
    input wire dff_preset_n,
    input wire dff_async_reset_n,
    input wire dff_d,
    input wire dff_q,
    input wire dff_q_n,
    // Dual-edge J-K flop
    input wire jk_clk,
    input wire jk_rising_edge_enable,
    input wire jk_preset_n,
    input wire jk_async_reset_n,
    input wire jk_j,
    input wire jk_k,
    input wire jk_q,
    // Data latch array
    input wire dl_preset_n,
    input wire dl_async_reset_n,
    input wire dl_gate,
    input wire [`DL_WIDTH-1:0] dl_data,
    input wire [`DL_WIDTH-1:0] dl_q,
    input wire [`DL_WIDTH-1:0] dl_q_n
);
    // Assertions look four cycles back, so they wait until that history lies after reset
    reg [2:0] up_cnt_r;
    wire armed = up_cnt_r == 3'h5;
    wire dff_run = dff_preset_n & dff_async_reset_n;
    wire jk_run = jk_preset_n & jk_async_reset_n;
    wire dl_run = dl_preset_n & dl_async_reset_n;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) up_cnt_r <= 3'h0;
        else if (!armed) up_cnt_r <= up_cnt_r + 3'h1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_dff_clear_force: assert property (armed && $past(dff_preset_n, 3) && !$past(dff_async_reset_n, 3)
        |-> !dff_q && dff_q_n) else $error("d flop clear override wrong");
    a_dff_both_low: assert property (armed && !$past(dff_preset_n, 3) && !$past(dff_async_reset_n, 3)
        |-> dff_q && dff_q_n) else $error("d flop unstable outputs wrong");
    a_dff_rise_capture: assert property (armed && $past(dff_run, 3) && $past(dff_rising_edge_enable, 3)
        && $past(dff_clk, 3) && !$past(dff_clk, 4) |-> dff_q == $past(dff_d, 3) && dff_q_n != dff_q)
        else $error("d flop rising capture wrong");
    a_dff_fall_capture: assert property (armed && $past(dff_run, 3) && $past(dff_falling_edge_enable, 3)
        && !$past(dff_clk, 3) && $past(dff_clk, 4) |-> dff_q == $past(dff_d, 3) && dff_q_n != dff_q)
        else $error("d flop falling capture wrong");
    a_jk_rise_result: assert property (armed && $past(jk_run, 3) && $past(jk_rising_edge_enable, 3)
        && $past(jk_clk, 3) && !$past(jk_clk, 4)
        |-> jk_q == ($past(jk_j, 3) & !$past(jk_q) | !$past(jk_k, 3) & $past(jk_q)))
        else $error("jk flop edge result wrong");
    a_dl_follow: assert property (armed && $past(dl_run, 3) && $past(dl_gate, 3)
        |-> dl_q == $past(dl_data, 3) && dl_q_n == ~dl_q) else $error("data latch not following");
    a_dl_hold: assert property (armed && $past(dl_run, 3) && !$past(dl_gate, 3) |-> $stable(dl_q))
        else $error("data latch not holding");
    a_dl_clear_force: assert property (armed && $past(dl_preset_n, 3) && !$past(dl_async_reset_n, 3)
        |-> dl_q == '0 && dl_q_n == '1) else $error("data latch clear override wrong");
endmodule // edge_latch_monitor

bind dual_edge_flops_gated_latches edge_latch_monitor i_monitor (.ref_clk, .rst_n, .dff_clk,
    .dff_rising_edge_enable, .dff_falling_edge_enable, .dff_preset_n, .dff_async_reset_n, .dff_d, .dff_q,
    .dff_q_n, .jk_clk, .jk_rising_edge_enable, .jk_preset_n, .jk_async_reset_n, .jk_j, .jk_k, .jk_q,
    .dl_preset_n, .dl_async_reset_n, .dl_gate, .dl_data, .dl_q, .dl_q_n);

/* File: tb/prim_clock_source.sv */
`timescale 1ns/1ps
module prim_clock_source (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Request and primitive clock
    input wire toggle,
    output reg pclk
);
    // One flip per request; callers space requests so each level outlasts the synchroniser
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) pclk <= 1'b0;
        else if (toggle) pclk <= ~pclk;
    end
endmodule // prim_clock_source

/* File: tb/dual_edge_flops_gated_latches_tb.sv */
`timescale 1ns/1ps
`include "edge_latch_regs.vh"
module dual_edge_flops_gated_latches_tb;
    logic ref_clk, rst_n, reg_wr, reg_rd, dff_tog, jk_tog, dff_clk, jk_clk, unstable_seen;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic dff_rising_edge_enable, dff_falling_edge_enable, dff_preset_n, dff_async_reset_n, dff_d, dff_q, dff_q_n;
    logic jk_rising_edge_enable, jk_falling_edge_enable, jk_preset_n, jk_async_reset_n, jk_j, jk_k, jk_q, jk_q_n;
    logic srl_preset_n, srl_async_reset_n, srl_gate, dl_preset_n, dl_async_reset_n, dl_gate;
    logic [3:0] srl_set, srl_reset, srl_q, srl_q_n;
    logic [7:0] dl_data, dl_q, dl_q_n;
    int err_total, checks;
    prim_clock_source i_dff_src (.ref_clk, .rst_n, .toggle(dff_tog), .pclk(dff_clk));
    prim_clock_source i_jk_src (.ref_clk, .rst_n, .toggle(jk_tog), .pclk(jk_clk));
    dual_edge_flops_gated_latches i_dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .dff_clk, .dff_rising_edge_enable, .dff_falling_edge_enable, .dff_preset_n, .dff_async_reset_n, .dff_d,
        .dff_q, .dff_q_n, .jk_clk, .jk_rising_edge_enable, .jk_falling_edge_enable, .jk_preset_n,
        .jk_async_reset_n, .jk_j, .jk_k, .jk_q, .jk_q_n, .srl_preset_n, .srl_async_reset_n, .srl_gate, .srl_set,
        .srl_reset, .srl_q, .srl_q_n, .dl_preset_n, .dl_async_reset_n, .dl_gate, .dl_data, .dl_q, .dl_q_n,
        .unstable_seen);
    always #50 ref_clk = ~ref_clk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic settle;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", reg_rdata, exp);
    endtask
    task automatic pulse(input logic jk);
        @(posedge ref_clk);
        if (jk) jk_tog <= 1'b1;
        else dff_tog <= 1'b1;
        @(posedge ref_clk);
        jk_tog <= 1'b0;
        dff_tog <= 1'b0;
        settle;
    endtask
    task automatic t_regs;
        #1;
        check("flops", {dff_q, dff_q_n, jk_q, jk_q_n}, 4'h5);
        check("latches", {dl_q, dl_q_n, srl_q, srl_q_n}, 24'h00ff0f);
        check("unstable_seen", unstable_seen, 1'b0);
        reg_check(`OFS_FLAGS, 32'h0);
        reg_check(`OFS_CTRL, `CTRL_RESET);
        reg_check(8'h10, 32'h0);
        reg_write(`OFS_CTRL, 32'h0);
        reg_check(`OFS_CTRL, 32'h0);
        reg_write(`OFS_CTRL, 32'h1);
        $display("t_regs done");
    endtask
    task automatic t_force;
        logic [1:0] pc;
        @(posedge ref_clk);
        dl_gate <= 1'b1;
        dl_data <= 8'hff;
        for (int i = 2; i >= 0; i--) begin
            pc = i[1:0];
            @(posedge ref_clk);
            {dff_preset_n, dff_async_reset_n} <= pc;
            {jk_preset_n, jk_async_reset_n} <= pc;
            {srl_preset_n, srl_async_reset_n} <= pc;
            {dl_preset_n, dl_async_reset_n} <= pc;
            settle;
            check("dff", {dff_q, dff_q_n}, {~pc});
            check("jk", {jk_q, jk_q_n}, {~pc});
            check("srl", {srl_q, srl_q_n}, {{4{~pc[1]}}, {4{~pc[0]}}});
            check("dl", {dl_q, dl_q_n}, {{8{~pc[1]}}, {8{~pc[0]}}});
        end
        check("unstable_seen", unstable_seen, 1'b1);
        reg_check(`OFS_FLAGS, 32'hf);
        @(posedge ref_clk);
        {dff_preset_n, dff_async_reset_n, jk_preset_n, jk_async_reset_n} <= 4'hf;
        {srl_preset_n, srl_async_reset_n, dl_preset_n, dl_async_reset_n} <= 4'hf;
        $display("t_force done");
    endtask
    task automatic t_dff;
        logic [17:0] seq;
        logic exp;
        seq = 18'b110010001001100111;
        exp = 1'b0;
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            {dff_d, dff_rising_edge_enable, dff_falling_edge_enable} <= seq[17-3*i -: 3];
            if (seq[16-3*i-i%2]) exp = seq[17-3*i];
            pulse(1'b0);
            check("dff", {dff_q, dff_q_n}, {exp, ~exp});
        end
        $display("t_dff done");
    endtask
    task automatic t_jk;
        logic [11:0] seq;
        logic exp;
        seq = 12'b011000111101;
        exp = 1'b0;
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            {jk_j, jk_k} <= seq[11-2*i -: 2];
            exp = seq[11-2*i] & ~exp | ~seq[10-2*i] & exp;
            pulse(1'b1);
            check("jk", {jk_q, jk_q_n}, {exp, ~exp});
        end
        $display("t_jk done");
    endtask
    task automatic t_latch;
        @(posedge ref_clk);
        srl_gate <= 1'b1;
        dl_data <= 8'ha5;
        {srl_set, srl_reset} <= 8'h3c;
        settle;
        check("dl", {dl_q, dl_q_n}, 16'ha55a);
        check("srl", {srl_q, srl_q_n}, 8'h3c);
        @(posedge ref_clk);
        {srl_gate, dl_gate} <= 2'b00;
        @(posedge ref_clk);
        dl_data <= 8'h3c;
        {srl_set, srl_reset} <= 8'h41;
        settle;
        check("dl", {dl_q, dl_q_n}, 16'ha55a);
        check("srl", {srl_q, srl_q_n}, 8'h3c);
        @(posedge ref_clk);
        {srl_gate, dl_gate} <= 2'b11;
        settle;
        check("dl", {dl_q, dl_q_n}, 16'h3cc3);
        check("srl", {srl_q, srl_q_n}, 8'h69);
        reg_check(`OFS_LATCH_Q, 32'h3c06);
        reg_check(`OFS_STATUS, 32'h1);
        $display("t_latch done");
    endtask
    task automatic t_flags;
        reg_write(`OFS_FLAGS, 32'hf);
        reg_check(`OFS_FLAGS, 32'h0);
        #1;
        check("unstable_seen", unstable_seen, 1'b0);
        @(posedge ref_clk);
        {srl_set, srl_reset} <= 8'h88;
        settle;
        check("srl", {srl_q, srl_q_n}, 8'he9);
        check("unstable_seen", unstable_seen, 1'b1);
        $display("t_flags done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        ref_clk = 0;
        rst_n = 0;
        {reg_wr, reg_rd, dff_tog, jk_tog, reg_addr, reg_wdata} = '0;
        {dff_rising_edge_enable, dff_falling_edge_enable, dff_d, jk_j, jk_k} = '0;
        {jk_rising_edge_enable, jk_falling_edge_enable} = 2'b11;
        {dff_preset_n, dff_async_reset_n, jk_preset_n, jk_async_reset_n} = 4'hf;
        {srl_preset_n, srl_async_reset_n, dl_preset_n, dl_async_reset_n} = 4'hf;
        {srl_gate, dl_gate, srl_set, srl_reset, dl_data} = '0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_regs;
        t_force;
        t_dff;
        t_jk;
        t_latch;
        t_flags;
        print_verdict;
    end
    // Whole run needs well under a thousand cycles; this is ten times that
    initial begin
        #1000000;
        err_total++;
        print_verdict;
    end
endmodule // dual_edge_flops_gated_latches_tb
